/* mbw_cfg.svh */
// Constants of the multi-write request handler: codes, map, framing.
// Assumes inclusion by name from the package and the design file.
`ifndef MBW_CFG_SVH
`define MBW_CFG_SVH
`define MBW_FC_COILS 8'h0f
`define MBW_FC_REGS 8'h10
`define MBW_EXC_BIT 8'h80
`define MBW_ERR_FUNC 8'h01
`define MBW_ERR_ADDR 8'h02
`define MBW_ERR_VALUE 8'h03
`define MBW_ERR_CHECKSUM 8'h09
`define MBW_CH_COLON 8'h3a
`define MBW_CH_CR 8'h0d
`define MBW_CH_LF 8'h0a
`define MBW_HDR_LEN 8'h07
`define MBW_MAX_COILS 16'h07b0
`define MBW_MAX_REGS 16'h007b
`define MBW_IO_SIZE 17'h00080
`define MBW_RELAY_BASE 17'h01000
`define MBW_RELAY_END 17'h01800
`define MBW_WORD_BASE 16'h7000
`define MBW_DATA_END 17'h00200
`define MBW_TIMER_BASE 17'h003e8
`define MBW_COUNTER_BASE 17'h007d0
`define MBW_WMEM_BASE 17'h00bb8
`define MBW_SMALL_SIZE 17'h00100
`endif

/* mbw_handler.sv */
// Modbus slave handler for force-multiple-coils and preset-multiple-registers,
// with exception replies and a response FIFO.
// Assumes a byte source (UART, frame gap and CRC check upstream for RTU)
// and a byte sink on the same clock; CRC generation for RTU replies is outside.
`timescale 1ns/1ns
`include "mbw_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module mbw_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Filling side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Draining side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    logic push;
    logic pop;

    // Extra pointer bit tells full from empty
    assign in_ready_out = (wr_r - rd_r) != (AW + 1)'(DEPTH);
    assign out_valid_out = wr_r != rd_r;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_r[AW-1:0]];

    // Storage has no reset; only pointers matter
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= in_data_in;
        end
    end

    // Pointers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) wr_r <= wr_r + 1'b1;
            if (pop) rd_r <= rd_r + 1'b1;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module mbw_handler import mbw_pkg::*; #(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Configuration
    input wire logic [7:0] slave_addr_in,
    input wire logic ascii_mode_in,
    // Received characters or bytes
    input wire logic rx_valid_in,
    output logic rx_ready_out,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_end_in,
    input wire logic crc_ok_in,
    // Writes toward the data areas
    output logic wr_valid_out,
    output mbw_wr_t wr_out,
    // Reply stream
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    output mbw_tx_t tx_out
);
    logic [7:0] buf_r [256];
    mbw_state_t state_r;
    logic [7:0] len_r;
    logic [7:0] sum_r;
    logic [3:0] nib_r;
    logic half_r;
    logic inframe_r;
    logic bad_r;
    logic frame_done;
    logic frame_drop;
    logic [10:0] idx_r;
    logic [4:0] tk_r;
    logic [7:0] err_r;
    logic [7:0] err_c;
    logic [7:0] plen;
    logic [15:0] start;
    logic [15:0] count;
    logic [7:0] bcount;
    logic [16:0] stop;
    logic [16:0] woff;
    logic [16:0] base_c;
    logic [1:0] area_c;
    logic for_us;
    logic f_push;
    logic f_ready;
    mbw_tx_t f_data;
    logic [7:0] rbyte;
    logic [7:0] lrc;
    logic [4:0] nbytes;
    logic [4:0] tk_last;
    logic [7:0] rx_byte;
    logic [4:0] hx;

    // Hex character to nibble, bit 4 flags a valid digit
    function automatic logic [4:0] hex_dec(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
        if (c >= 8'h41 && c <= 8'h46) return {1'b1, c[3:0] + 4'h9};
        return 5'h00;
    endfunction

    // Nibble to uppercase hex character
    function automatic logic [7:0] hex_enc(input logic [3:0] n);
        return (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Receive side
    assign rx_ready_out = state_r == ST_RX;
    assign hx = hex_dec(rx_data_in);
    assign rx_byte = ascii_mode_in ? {nib_r, hx[3:0]} : rx_data_in;
    // ASCII frame ends on line feed; RTU on the gap strobe
    assign frame_done = (state_r == ST_RX) && (ascii_mode_in
        ? (rx_valid_in && inframe_r && rx_data_in == `MBW_CH_LF && !bad_r)
        : (rx_end_in && crc_ok_in && !bad_r));
    assign frame_drop = (state_r == ST_RX) && (ascii_mode_in
        ? (rx_valid_in && inframe_r && rx_data_in == `MBW_CH_LF && bad_r)
        : (rx_end_in && !(crc_ok_in && !bad_r)));

    // Colon restarts the frame; hex pairs form bytes, CR is skipped
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            len_r <= 8'h00;
            sum_r <= 8'h00;
            nib_r <= 4'h0;
            half_r <= 1'b0;
            inframe_r <= 1'b0;
            bad_r <= 1'b0;
        end else if (frame_drop || state_r == ST_CHECK) begin
            // Length and sum stand until the check has read them
            len_r <= 8'h00;
            sum_r <= 8'h00;
            half_r <= 1'b0;
            inframe_r <= 1'b0;
            bad_r <= 1'b0;
        end else if (frame_done) begin
            half_r <= 1'b0;
            inframe_r <= 1'b0;
            bad_r <= 1'b0;
        end else if (state_r == ST_RX && rx_valid_in) begin
            if (ascii_mode_in && rx_data_in == `MBW_CH_COLON) begin
                len_r <= 8'h00;
                sum_r <= 8'h00;
                half_r <= 1'b0;
                inframe_r <= 1'b1;
                bad_r <= 1'b0;
            end else if (ascii_mode_in && (!inframe_r || rx_data_in == `MBW_CH_CR)) begin
                half_r <= half_r;
            end else if (ascii_mode_in && !hx[4]) begin
                bad_r <= 1'b1;
            end else if (ascii_mode_in && !half_r) begin
                nib_r <= hx[3:0];
                half_r <= 1'b1;
            end else begin
                half_r <= 1'b0;
                len_r <= len_r + 8'h01;
                sum_r <= sum_r + rx_byte;
                if (len_r == 8'hff) bad_r <= 1'b1; // Overlong frame is dropped
            end
        end
    end

    // Frame buffer, written only by the receive path
    always_ff @(posedge clk_in) begin
        if (state_r == ST_RX && rx_valid_in && (!ascii_mode_in || (inframe_r && half_r
            && hx[4]))) begin
            buf_r[len_r] <= rx_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request check
    assign plen = ascii_mode_in ? len_r - 8'h01 : len_r;
    assign start = {buf_r[2], buf_r[3]};
    assign count = {buf_r[4], buf_r[5]};
    assign bcount = buf_r[6];
    assign stop = {1'b0, start} + {1'b0, count};
    assign woff = {1'b0, start} - {1'b0, `MBW_WORD_BASE};
    assign for_us = buf_r[0] == slave_addr_in;

    // Area lookup and exception code, checked in priority order
    always_comb begin
        err_c = 8'h00;
        area_c = AR_DATA;
        base_c = 17'h00000;
        if (ascii_mode_in && sum_r != 8'h00) begin
            err_c = `MBW_ERR_CHECKSUM;
        end else if (buf_r[1] != `MBW_FC_COILS && buf_r[1] != `MBW_FC_REGS) begin
            err_c = `MBW_ERR_FUNC;
        end else if (plen < `MBW_HDR_LEN) begin
            err_c = `MBW_ERR_VALUE;
        end else if (buf_r[1] == `MBW_FC_COILS) begin
            if (count == 16'h0000 || count > `MBW_MAX_COILS
                || {5'h00, bcount} != (count[15:3] + {12'h000, |count[2:0]})
                || plen != `MBW_HDR_LEN + bcount) begin
                err_c = `MBW_ERR_VALUE;
            end else if (stop <= `MBW_IO_SIZE) begin
                area_c = 2'h0;
            end else if ({1'b0, start} >= `MBW_RELAY_BASE && stop <= `MBW_RELAY_END) begin
                area_c = 2'h1;
                base_c = `MBW_RELAY_BASE;
            end else begin
                err_c = `MBW_ERR_ADDR;
            end
        end else begin
            if (count == 16'h0000 || count > `MBW_MAX_REGS
                || {8'h00, bcount} != {count[14:0], 1'b0}
                || plen != `MBW_HDR_LEN + bcount) begin
                err_c = `MBW_ERR_VALUE;
            end else if (start < `MBW_WORD_BASE) begin
                err_c = `MBW_ERR_ADDR;
            end else if (woff + {1'b0, count} <= `MBW_DATA_END) begin
                area_c = AR_DATA;
            end else if (woff >= `MBW_TIMER_BASE
                && woff + {1'b0, count} <= `MBW_TIMER_BASE + `MBW_SMALL_SIZE) begin
                area_c = AR_TIMER;
                base_c = `MBW_TIMER_BASE;
            end else if (woff >= `MBW_COUNTER_BASE
                && woff + {1'b0, count} <= `MBW_COUNTER_BASE + `MBW_SMALL_SIZE) begin
                area_c = AR_COUNTER;
                base_c = `MBW_COUNTER_BASE;
            end else if (woff >= `MBW_WMEM_BASE
                && woff + {1'b0, count} <= `MBW_WMEM_BASE + `MBW_SMALL_SIZE) begin
                area_c = AR_WMEM;
                base_c = `MBW_WMEM_BASE;
            end else begin
                err_c = `MBW_ERR_ADDR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer; frames for other slaves are dropped silently
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= ST_RX;
        end else begin
            case (state_r)
                ST_RX: if (frame_done) state_r <= ST_CHECK;
                ST_CHECK: begin
                    if (!for_us) state_r <= ST_RX;
                    else if (err_c != 8'h00) state_r <= ST_RESP;
                    else state_r <= ST_EXEC;
                end
                ST_EXEC: if ({5'h00, idx_r} == count - 16'h0001) state_r <= ST_RESP;
                ST_RESP: if (f_ready && tk_r == tk_last) state_r <= ST_RX;
                default: state_r <= ST_RX;
            endcase
        end
    end

    // Latched exception code of the checked request
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_r <= 8'h00;
        end else if (state_r == ST_CHECK) begin
            err_r <= err_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write issue: one point or word per cycle, only after the whole check
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idx_r <= 11'h000;
            wr_valid_out <= 1'b0;
            wr_out <= '0;
        end else begin
            wr_valid_out <= state_r == ST_EXEC;
            if (state_r == ST_CHECK) begin
                idx_r <= 11'h000;
                wr_out.area <= area_c;
                wr_out.is_bit <= buf_r[1] == `MBW_FC_COILS;
                wr_out.index <= buf_r[1] == `MBW_FC_COILS
                    ? start[10:0] - base_c[10:0]
                    : woff[10:0] - base_c[10:0];
            end else if (state_r == ST_EXEC) begin
                idx_r <= idx_r + 11'h001;
                if (idx_r != 11'h000) wr_out.index <= wr_out.index + 11'h001;
                if (wr_out.is_bit) begin
                    // Point n is bit n%8 of byte n/8, LSB first
                    wr_out.data <= {15'h0000,
                        buf_r[8'(`MBW_HDR_LEN + idx_r[10:3])][idx_r[2:0]]};
                end else begin
                    // High byte first on the wire
                    wr_out.data <= {buf_r[8'(`MBW_HDR_LEN + {idx_r[6:0], 1'b0})],
                        buf_r[8'(`MBW_HDR_LEN + {idx_r[6:0], 1'b0} + 8'h01)]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reply bytes: echo header on success, exception triple on error
    assign nbytes = (err_r != 8'h00) ? 5'd3 : 5'd6;
    assign lrc = 8'h00 - (buf_r[0] + ((err_r != 8'h00)
        ? ((buf_r[1] | `MBW_EXC_BIT) + err_r)
        : (buf_r[1] + buf_r[2] + buf_r[3] + buf_r[4] + buf_r[5])));
    assign tk_last = ascii_mode_in ? nbytes + nbytes + 5'd4 : nbytes - 5'd1;

    // Byte k of the reply, byte nbytes is the checksum
    function automatic logic [7:0] reply_byte(input logic [4:0] k);
        if (k == nbytes) return lrc;
        if (k == 5'd1 && err_r != 8'h00) return buf_r[1] | `MBW_EXC_BIT;
        if (k == 5'd2 && err_r != 8'h00) return err_r;
        return buf_r[k];
    endfunction

    // Character stream: colon, hex pairs, checksum, CR LF
    always_comb begin
        rbyte = reply_byte(ascii_mode_in ? (tk_r - 5'd1) >> 1 : tk_r);
        f_data.last = tk_r == tk_last;
        if (!ascii_mode_in) f_data.data = rbyte;
        else if (tk_r == 5'd0) f_data.data = `MBW_CH_COLON;
        else if (tk_r == tk_last - 5'd1) f_data.data = `MBW_CH_CR;
        else if (tk_r == tk_last) f_data.data = `MBW_CH_LF;
        else if (tk_r[0]) f_data.data = hex_enc(rbyte[7:4]);
        else f_data.data = hex_enc(rbyte[3:0]);
    end

    // Character counter stalls while the FIFO is full
    assign f_push = state_r == ST_RESP;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tk_r <= 5'd0;
        end else if (state_r != ST_RESP) begin
            tk_r <= 5'd0;
        end else if (f_ready) begin
            tk_r <= tk_r + 5'd1;
        end
    end

    // Reply FIFO toward the line
    mbw_fifo #(.WIDTH($bits(mbw_tx_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(f_push),
        .in_ready_out(f_ready),
        .in_data_in(f_data),
        .out_valid_out(tx_valid_out),
        .out_ready_in(tx_ready_in),
        .out_data_out(tx_out)
    );
endmodule

/* mbw_handler_test.sv */
// Self-checking bench for the multi-write request handler.
// Assumes the master model and the bound monitor.
`timescale 1ns/1ns
module mbw_handler_test import mbw_pkg::*;;
    logic clk_in, rst_n_in, ascii_mode_r;
    logic rx_valid, rx_ready, rx_end, crc_ok, wr_valid, tx_valid, tx_ready;
    logic [7:0] rx_data;
    mbw_wr_t wr_data;
    mbw_tx_t tx_data;
    mbw_wr_t wr_q[$], ew[$];
    mbw_tx_t ec[$];
    logic [7:0] rq[$], rs[$];
    int error_cnt = 0;
    int check_count = 0;

    mbw_handler #(.FIFO_DEPTH(8)) u_mbw_handler (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .slave_addr_in(8'h03),
        .ascii_mode_in(ascii_mode_r), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
        .rx_data_in(rx_data), .rx_end_in(rx_end), .crc_ok_in(crc_ok),
        .wr_valid_out(wr_valid), .wr_out(wr_data), .tx_valid_out(tx_valid),
        .tx_ready_in(tx_ready), .tx_out(tx_data));
    mbw_master_model u_mbw_master_model (
        .clk_in(clk_in), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
        .rx_data_out(rx_data), .rx_end_out(rx_end), .crc_ok_out(crc_ok),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_in(tx_data));

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // Writes have no handshake, so every pulse is logged
    always @(posedge clk_in)
        if (wr_valid)
            wr_q.push_back(wr_data);

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_ch(input string what, input logic [8:0] exp, input logic [8:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_wr(input string what, input logic [29:0] exp, input logic [29:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        error_cnt += u_mbw_master_model.tmo_cnt;
        $display("Checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic push_hex(input logic [7:0] b);
        ec.push_back({1'b0, u_mbw_master_model.hx(b[7:4])});
        ec.push_back({1'b0, u_mbw_master_model.hx(b[3:0])});
    endtask

    // Sends rq, then judges the reply against rs and the writes against ew
    task automatic run(input string name, input bit rtu, input bit bad);
        int n;
        ec.delete();
        if (rs.size() > 0) begin
            if (!rtu)
                ec.push_back(9'h03a);
            foreach (rs[i])
                if (rtu)
                    ec.push_back({1'b0, rs[i]});
                else
                    push_hex(rs[i]);
            if (!rtu) begin
                push_hex(u_mbw_master_model.sum_neg(rs));
                ec.push_back(9'h00d);
                ec.push_back(9'h00a);
            end
            ec[$].last = 1'b1;
        end
        u_mbw_master_model.rsp_q.delete();
        wr_q.delete();
        ascii_mode_r <= !rtu;
        @(posedge clk_in);
        u_mbw_master_model.send(rq, rtu, bad);
        n = 0;
        while (u_mbw_master_model.rsp_q.size() < ec.size() && n < 3000) begin
            @(posedge clk_in);
            n++;
        end
        if (n == 3000) begin
            error_cnt++;
            give_verdict();
        end
        // Quiet spell shows any stray reply or write
        repeat (30) @(posedge clk_in);
        chk_ch("reply length", 9'(ec.size()), 9'(u_mbw_master_model.rsp_q.size()));
        foreach (ec[i])
            if (i < u_mbw_master_model.rsp_q.size())
                chk_ch("reply char", ec[i], u_mbw_master_model.rsp_q[i]);
        chk_wr("write count", 30'(ew.size()), 30'(wr_q.size()));
        foreach (ew[i])
            if (i < wr_q.size())
                chk_wr("write", ew[i], wr_q[i]);
        $display("Test %s done", name);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Eleven points from point 20, slow sink fills the FIFO
    task automatic t_coils();
        rq = '{8'h03, 8'h0f, 8'h00, 8'h14, 8'h00, 8'h0b, 8'h02, 8'hd1, 8'h05};
        rs = rq[0:5];
        ew.delete();
        for (int i = 0; i < 11; i++)
            ew.push_back({1'b1, 2'h0, 11'(20 + i), 15'h0, rq[7 + i / 8][i % 8]});
        u_mbw_master_model.slow_r = 1'b1;
        run("coils", 1'b0, 1'b0);
        u_mbw_master_model.slow_r = 1'b0;
    endtask
    task automatic t_regs();
        rq = '{8'h03, 8'h10, 8'h70, 8'h00, 8'h00, 8'h03, 8'h06,
               8'hd1, 8'h03, 8'h0a, 8'h12, 8'h04, 8'h05};
        rs = rq[0:5];
        ew.delete();
        for (int i = 0; i < 3; i++)
            ew.push_back({1'b0, 2'h0, 11'(i), rq[7 + 2 * i], rq[8 + 2 * i]});
        run("regs", 1'b1, 1'b0);
    endtask
    // Word 255 of each word area, the top of all but the data area, then the last relay
    task automatic t_areas();
        logic [15:0] a;
        for (int k = 0; k < 4; k++) begin
            a = 16'h7000 + 16'(k * 1000 + 255);
            rq = '{8'h03, 8'h10, a[15:8], a[7:0], 8'h00, 8'h01, 8'h02, 8'h12, 8'(k)};
            rs = rq[0:5];
            ew = '{{1'b0, 2'(k), 11'h0ff, 8'h12, 8'(k)}};
            run("word area", 1'b0, 1'b0);
        end
        rq = '{8'h03, 8'h0f, 8'h17, 8'hff, 8'h00, 8'h01, 8'h01, 8'h01};
        rs = rq[0:5];
        ew = '{{1'b1, 2'h1, 11'h7ff, 16'h0001}};
        run("relay", 1'b0, 1'b0);
    endtask
    task automatic t_errors();
        for (int k = 0; k < 5; k++) begin
            case (k)
                0: rq = '{8'h03, 8'h0f, 8'h00, 8'h14, 8'h00, 8'h01, 8'h01, 8'h01};
                1: rq = '{8'h03, 8'h03, 8'h70, 8'h00, 8'h00, 8'h01};
                2: rq = '{8'h03, 8'h10, 8'h70, 8'h00, 8'h00, 8'h00, 8'h00};
                3: rq = '{8'h03, 8'h0f, 8'h00, 8'h7f, 8'h00, 8'h02, 8'h01, 8'h03};
                default: rq = '{8'h03, 8'h10, 8'h72, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01};
            endcase
            rs = '{8'h03, rq[1] | 8'h80, k == 0 ? 8'h09 : k == 1 ? 8'h01 : k == 2 ? 8'h03 : 8'h02};
            ew.delete();
            run("exception", 1'b0, k == 0);
        end
    endtask
    // Bad CRC and a foreign address: silence and no writes
    task automatic t_drop();
        rq = '{8'h03, 8'h10, 8'h70, 8'h00, 8'h00, 8'h01, 8'h02, 8'h55, 8'haa};
        rs.delete();
        ew.delete();
        run("rtu bad crc", 1'b1, 1'b1);
        rq[0] = 8'h05;
        run("foreign", 1'b0, 1'b0);
    endtask

    initial begin
        rst_n_in = 1'b0;
        ascii_mode_r = 1'b1;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_coils();
        t_regs();
        t_areas();
        t_errors();
        t_drop();
        give_verdict();
    end
endmodule

/* mbw_master_model.sv */
// Master stand-in: sends request frames and sinks the replies.
// Assumes the handler's clock; the bench sets slow_r to stall the sink.
`timescale 1ns/1ns
module mbw_master_model import mbw_pkg::*; (
    // Clock
    input wire logic clk_in,
    // Request side
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic [7:0] rx_data_out,
    output logic rx_end_out,
    output logic crc_ok_out,
    // Reply side
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire mbw_tx_t tx_in
);
    logic slow_r;
    logic [2:0] cnt_r;
    mbw_tx_t rsp_q[$];
    int tmo_cnt;

    initial begin
        {rx_valid_out, rx_data_out, rx_end_out, crc_ok_out} = '0;
        tx_ready_out = 1'b1;
        slow_r = 1'b0;
        cnt_r = 3'h0;
        tmo_cnt = 0;
    end

    // Slow sink takes one cycle in eight, so the FIFO fills up
    always @(posedge clk_in) begin
        cnt_r <= cnt_r + 3'h1;
        tx_ready_out <= !slow_r || cnt_r == 3'h0;
        if (tx_valid_in && tx_ready_out)
            rsp_q.push_back(tx_in);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Upper-case hex digit
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    // Negated byte sum
    function automatic logic [7:0] sum_neg(input logic [7:0] b[$]);
        logic [7:0] s;
        s = 8'h00;
        foreach (b[i]) s += b[i];
        return -s;
    endfunction

    // One character, held until the handler takes it
    task automatic put(input logic [7:0] c);
        int n;
        n = 0;
        rx_valid_out <= 1'b1;
        rx_data_out <= c;
        do begin
            @(posedge clk_in);
            n++;
        end while (!rx_ready_in && n < 500);
        if (!rx_ready_in)
            tmo_cnt++;
    endtask

    // Whole request; bad spoils the sum or the CRC verdict
    task automatic send(input logic [7:0] b[$], input bit rtu, input bit bad);
        logic [7:0] s;
        s = sum_neg(b) ^ {7'h0, bad};
        if (!rtu)
            put(8'h3a);
        foreach (b[i]) begin
            if (rtu)
                put(b[i]);
            else begin
                put(hx(b[i][7:4]));
                put(hx(b[i][3:0]));
            end
        end
        if (!rtu) begin
            put(hx(s[7:4]));
            put(hx(s[3:0]));
            put(8'h0d);
            put(8'h0a);
        end
        rx_valid_out <= 1'b0;
        rx_data_out <= ~rx_data_out; // Released line shows no stale value
        if (rtu) begin
            rx_end_out <= 1'b1;
            crc_ok_out <= !bad;
            @(posedge clk_in);
            rx_end_out <= 1'b0;
            crc_ok_out <= bad;
        end
    endtask
endmodule

/* mbw_monitor.sv */
// Assertions on the write and reply ports of the handler.
// Assumes one clock and the handler's active-low reset.
`timescale 1ns/1ns
module mbw_monitor import mbw_pkg::*; (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Watched ports
    input wire logic ascii_mode_in,
    input wire logic rx_ready_out,
    input wire logic wr_valid_out,
    input wire mbw_wr_t wr_out,
    input wire logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire mbw_tx_t tx_out
);
    logic in_reply_r;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Inside a reply; lets the first character be picked out
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            in_reply_r <= 1'b0;
        else if (tx_valid_out && tx_ready_in)
            in_reply_r <= !tx_out.last;
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_reply_colon: assert property (
        tx_valid_out && ascii_mode_in && !in_reply_r |-> tx_out.data == 8'h3a)
        else $error("Reply does not open with a colon");
    chk_last_lf: assert property (
        tx_valid_out && ascii_mode_in && tx_out.last |-> tx_out.data == 8'h0a)
        else $error("Last reply character is not a line feed");
    chk_hex_chars: assert property (
        tx_valid_out && ascii_mode_in |-> tx_out.data inside
        {8'h3a, 8'h0d, 8'h0a, [8'h30:8'h39], [8'h41:8'h46]})
        else $error("Reply character outside the hex set");
    chk_tx_hold: assert property (
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_out))
        else $error("Reply character dropped or changed while stalled");
    chk_wr_step: assert property (
        wr_valid_out && $past(wr_valid_out) |-> wr_out.index == $past(wr_out.index) + 11'h1)
        else $error("Write index does not advance by one");
    chk_wr_busy: assert property (
        wr_valid_out |-> !rx_ready_out)
        else $error("Write issued while still receiving");
    chk_word_area: assert property (
        wr_valid_out && !wr_out.is_bit |->
        wr_out.index < ((wr_out.area == AR_DATA) ? 11'h200 : 11'h100))
        else $error("Word write beyond its area");
    chk_bit_area: assert property (
        wr_valid_out && wr_out.is_bit |->
        (wr_out.area == 2'h0) ? wr_out.index < 11'h080 : wr_out.area == 2'h1)
        else $error("Bit write beyond its area");
endmodule

bind mbw_handler mbw_monitor u_mbw_monitor (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ascii_mode_in(ascii_mode_in),
    .rx_ready_out(rx_ready_out), .wr_valid_out(wr_valid_out), .wr_out(wr_out),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .tx_out(tx_out));

/* mbw_pkg.sv */
// Types shared by the multi-write request handler, its bench and its monitor.
// Assumes mbw_cfg.svh sits in the same folder.
`include "mbw_cfg.svh"
package mbw_pkg;
    // One write toward the controller's data areas
    typedef struct packed {
        logic is_bit;
        logic [1:0] area;
        logic [10:0] index;
        logic [15:0] data;
    } mbw_wr_t;
    // One outgoing character or byte
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } mbw_tx_t;
    typedef enum logic [3:0] {
        ST_RX = 4'h1,
        ST_CHECK = 4'h2,
        ST_EXEC = 4'h4,
        ST_RESP = 4'h8
    } mbw_state_t;
    // Area codes on the write port
    typedef enum logic [1:0] {
        AR_DATA = 2'h0,
        AR_TIMER = 2'h1,
        AR_COUNTER = 2'h2,
        AR_WMEM = 2'h3
    } mbw_area_t;
endpackage
